// File: logic/tcc_timer.sv
// 16-bit capture/compare timer with wishbone register access.
// assumes timer_in_a/b are asynchronous pins, one 100 MHz clock.
// Function
// - direction bit 0 output, 1 input; resets ff
// - interval mode clears counter on a-match, irq
// - count clock chosen by prescale bits 1:0
// - interval period is compare plus one clocks
// - pulse generator drives square wave on output
// - period a+1, high width b+1 clocks
// - free-run edge on a captures into b
// - input a edge selected by bits 5:4
// - two equal samples before capture accepted
// - input b edge captures into reg a
// - opposite edge of a captures into a
// - restart mode captures b then clears counter unless a edge is both
// - edge codes 00 fall, 01 rise, 11 both
// - clocks: main, div4, div64, input a edge
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer #(
    parameter int cnt_width = 16
) (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    input  wire logic        timer_in_a,
    input  wire logic        timer_in_b,
    output var  logic        timer_out,
    output var  logic        timer_out_oe,
    output var  logic        match_a_irq,
    output var  logic        capture_b_irq,
    output var  logic        irq
);
    logic [cnt_width-1:0] main_counter;
    logic [cnt_width-1:0] capcmp_reg_a;
    logic [cnt_width-1:0] capcmp_reg_b;
    logic [7:0]           prescale_mode_reg;
    logic [7:0]           timer_mode_ctrl;
    logic [7:0]           capcmp_ctrl;
    logic [7:0]           timer_output_ctrl;
    logic [7:0]           port3_direction;
    logic [7:0]           port3_latch;
    logic [1:0]           irq_stat;
    logic [1:0]           irq_mask;
    logic                 out_ff;
    logic [5:0]           prediv;
    logic                 ack;
    logic [31:0]          rd_data;
    logic [1:0]           sync_a;
    logic [1:0]           sync_b;

    logic [cnt_width-1:0] next_main_counter;
    logic [cnt_width-1:0] next_capcmp_reg_a;
    logic [cnt_width-1:0] next_capcmp_reg_b;
    logic [7:0]           next_prescale_mode_reg;
    logic [7:0]           next_timer_mode_ctrl;
    logic [7:0]           next_capcmp_ctrl;
    logic [7:0]           next_timer_output_ctrl;
    logic [7:0]           next_port3_direction;
    logic [7:0]           next_port3_latch;
    logic [1:0]           next_irq_stat;
    logic [1:0]           next_irq_mask;
    logic                 next_out_ff;
    logic [5:0]           next_prediv;
    logic                 next_ack;
    logic [31:0]          next_rd_data;
    logic                 next_match_a_irq;
    logic                 next_capture_b_irq;

    logic       bus_req;
    logic       wr;
    logic       rd;
    logic       running;
    logic       tick;
    logic       samp;
    logic [1:0] mode;
    logic       match_a;
    logic       match_b;
    logic       cap_a;
    logic       cap_b;
    logic       cap_a_rev;
    logic       both_a;

    tcc_edge_if ea ();
    tcc_edge_if eb ();

    tcc_edge_det u_det_a (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .e       (ea)
    );
    tcc_edge_det u_det_b (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .e       (eb)
    );

    assign mode    = timer_mode_ctrl[1:0];
    assign running = (mode != tcc_pkg::tcc_mode_stop);

    // prescaler strobes; edge_a source counts on the filtered edge itself
    always_comb begin
        next_prediv = running ? prediv + 6'h01 : 6'h00;
        case (prescale_mode_reg[tcc_pkg::tcc_clk_sel_lo +: 2])
            tcc_pkg::tcc_clk_main:  samp = 1'b1;
            tcc_pkg::tcc_clk_div4:  samp = ((prediv & tcc_pkg::tcc_div4_mask) == 6'h00);
            tcc_pkg::tcc_clk_div64: samp = ((prediv & tcc_pkg::tcc_div64_mask) == 6'h00);
            default:                samp = 1'b1; // edge source samples on main clock
        endcase
        samp = samp & running;
        tick = (prescale_mode_reg[tcc_pkg::tcc_clk_sel_lo +: 2] == tcc_pkg::tcc_clk_edge_a)
               ? ea.valid : samp;
    end

    assign ea.strobe = samp;
    assign eb.strobe = samp;
    assign ea.pin    = sync_a[1];
    assign eb.pin    = sync_b[1];
    assign ea.sel    = prescale_mode_reg[tcc_pkg::tcc_edge_a_sel_lo +: 2];
    assign eb.sel    = prescale_mode_reg[tcc_pkg::tcc_edge_b_sel_lo +: 2];

    assign cap_a     = capcmp_ctrl[tcc_pkg::tcc_cap_a_bit];
    assign cap_a_rev = capcmp_ctrl[tcc_pkg::tcc_cap_a_rev_bit];
    assign cap_b     = capcmp_ctrl[tcc_pkg::tcc_cap_b_bit];
    assign both_a    = (ea.sel == tcc_pkg::tcc_edge_both);
    assign match_a   = running && !cap_a && (main_counter == capcmp_reg_a);
    assign match_b   = running && !cap_b && (main_counter == capcmp_reg_b);

    assign bus_req = wb_cyc_i & wb_stb_i & ~ack;
    assign wr      = bus_req & wb_we_i & wb_sel_i[0];
    assign rd      = bus_req & ~wb_we_i;

    always_comb begin
        logic a_edge_cap;
        logic a_rev_edge;
        logic ev_a;
        logic ev_b;
        a_edge_cap = running && !both_a
                     && (prescale_mode_reg[tcc_pkg::tcc_clk_sel_lo +: 2] != tcc_pkg::tcc_clk_edge_a);
        a_rev_edge = (ea.sel == tcc_pkg::tcc_edge_rise) ? ea.fall : ea.rise;
        next_main_counter = main_counter;
        next_capcmp_reg_a = capcmp_reg_a;
        next_capcmp_reg_b = capcmp_reg_b;
        next_out_ff       = out_ff;
        ev_a = 1'b0;
        ev_b = 1'b0;
        if (!running) begin
            next_main_counter = tcc_pkg::tcc_cnt_zero;
        end else if (tick) begin
            next_main_counter = main_counter + tcc_pkg::tcc_cnt_one;
            if (mode == tcc_pkg::tcc_mode_clr_a && match_a) begin
                next_main_counter = tcc_pkg::tcc_cnt_zero;
                ev_a = 1'b1;
            end
            if (match_a && timer_output_ctrl[tcc_pkg::tcc_inv_a_bit]) begin
                next_out_ff = 1'b1;
            end
            if (match_b && timer_output_ctrl[tcc_pkg::tcc_inv_b_bit]) begin
                next_out_ff = ~out_ff;
            end
        end
        // captures; single-edge check keeps both-edge selection from loading reg a
        if (running && cap_b && ea.valid) begin
            next_capcmp_reg_b = main_counter;
            ev_b = 1'b1;
            if (mode == tcc_pkg::tcc_mode_restart && !both_a) begin
                next_main_counter = tcc_pkg::tcc_cnt_zero;
            end
        end
        if (running && cap_a) begin
            if (cap_a_rev && a_edge_cap && (ea.sel == tcc_pkg::tcc_edge_fall ||
                ea.sel == tcc_pkg::tcc_edge_rise) && a_rev_edge && samp) begin
                next_capcmp_reg_a = main_counter;
            end else if (!cap_a_rev && eb.valid) begin
                next_capcmp_reg_a = main_counter;
                ev_a = 1'b1;
            end
        end
        if (wr && wb_adr_i == tcc_pkg::tcc_off_reg_a) begin
            next_capcmp_reg_a = wb_dat_i[cnt_width-1:0];
        end
        if (wr && wb_adr_i == tcc_pkg::tcc_off_reg_b) begin
            next_capcmp_reg_b = wb_dat_i[cnt_width-1:0];
        end
        if (wr && wb_adr_i == tcc_pkg::tcc_off_outctl) begin
            if (wb_dat_i[tcc_pkg::tcc_lv_set_bit] && !wb_dat_i[tcc_pkg::tcc_lv_clr_bit]) begin
                next_out_ff = 1'b1;
            end else if (wb_dat_i[tcc_pkg::tcc_lv_clr_bit] && !wb_dat_i[tcc_pkg::tcc_lv_set_bit]) begin
                next_out_ff = 1'b0;
            end
        end
        next_match_a_irq   = ev_a;
        next_capture_b_irq = ev_b;
        // read clears status, a new event in the same cycle wins
        next_irq_stat = irq_stat;
        if (rd && wb_adr_i == tcc_pkg::tcc_off_irq_stat) begin
            next_irq_stat = 2'h0;
        end
        next_irq_stat[tcc_pkg::tcc_irq_match_a]   = next_irq_stat[tcc_pkg::tcc_irq_match_a] | ev_a;
        next_irq_stat[tcc_pkg::tcc_irq_capture_b] = next_irq_stat[tcc_pkg::tcc_irq_capture_b] | ev_b;
    end

    // register writes and reads
    always_comb begin
        next_prescale_mode_reg = prescale_mode_reg;
        next_timer_mode_ctrl   = timer_mode_ctrl;
        next_capcmp_ctrl       = capcmp_ctrl;
        next_timer_output_ctrl = timer_output_ctrl;
        next_port3_direction   = port3_direction;
        next_port3_latch       = port3_latch;
        next_irq_mask          = irq_mask;
        next_ack               = bus_req;
        next_rd_data           = rd_data;
        if (wr) begin
            case (wb_adr_i)
                tcc_pkg::tcc_off_prescale: next_prescale_mode_reg = wb_dat_i[7:0] & 8'hf3;
                tcc_pkg::tcc_off_mode:     next_timer_mode_ctrl   = wb_dat_i[7:0] & 8'h03;
                tcc_pkg::tcc_off_capcmp:   next_capcmp_ctrl       = wb_dat_i[7:0] & 8'h07;
                // set/clear request bits are strobes and read back as zero
                tcc_pkg::tcc_off_outctl:   next_timer_output_ctrl = wb_dat_i[7:0] & 8'h13;
                tcc_pkg::tcc_off_port3dir: next_port3_direction   = wb_dat_i[7:0] | 8'hc0;
                tcc_pkg::tcc_off_port3lat: next_port3_latch       = wb_dat_i[7:0];
                tcc_pkg::tcc_off_irq_mask: next_irq_mask          = wb_dat_i[1:0];
                default: ;
            endcase
        end
        if (rd) begin
            case (wb_adr_i)
                tcc_pkg::tcc_off_counter:  next_rd_data = {16'h0000, main_counter};
                tcc_pkg::tcc_off_reg_a:    next_rd_data = {16'h0000, capcmp_reg_a};
                tcc_pkg::tcc_off_reg_b:    next_rd_data = {16'h0000, capcmp_reg_b};
                tcc_pkg::tcc_off_prescale: next_rd_data = {24'h000000, prescale_mode_reg};
                tcc_pkg::tcc_off_mode:     next_rd_data = {24'h000000, timer_mode_ctrl};
                tcc_pkg::tcc_off_capcmp:   next_rd_data = {24'h000000, capcmp_ctrl};
                tcc_pkg::tcc_off_outctl:   next_rd_data = {24'h000000, timer_output_ctrl};
                tcc_pkg::tcc_off_port3dir: next_rd_data = {24'h000000, port3_direction};
                tcc_pkg::tcc_off_port3lat: next_rd_data = {24'h000000, port3_latch};
                tcc_pkg::tcc_off_irq_stat: next_rd_data = {30'h00000000, irq_stat};
                tcc_pkg::tcc_off_irq_mask: next_rd_data = {30'h00000000, irq_mask};
                default:                   next_rd_data = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            main_counter      <= '0;
            capcmp_reg_a      <= '0;
            capcmp_reg_b      <= '0;
            prescale_mode_reg <= tcc_pkg::tcc_byte_rst;
            timer_mode_ctrl   <= tcc_pkg::tcc_byte_rst;
            capcmp_ctrl       <= tcc_pkg::tcc_byte_rst;
            timer_output_ctrl <= tcc_pkg::tcc_byte_rst;
            port3_direction   <= tcc_pkg::tcc_port3dir_rst;
            port3_latch       <= tcc_pkg::tcc_byte_rst;
            irq_stat          <= 2'h0;
            irq_mask          <= 2'h0;
            out_ff            <= 1'b0;
            prediv            <= 6'h00;
            ack               <= 1'b0;
            rd_data           <= 32'h00000000;
            match_a_irq       <= 1'b0;
            capture_b_irq     <= 1'b0;
            sync_a            <= 2'h0;
            sync_b            <= 2'h0;
        end else begin
            main_counter      <= next_main_counter;
            capcmp_reg_a      <= next_capcmp_reg_a;
            capcmp_reg_b      <= next_capcmp_reg_b;
            prescale_mode_reg <= next_prescale_mode_reg;
            timer_mode_ctrl   <= next_timer_mode_ctrl;
            capcmp_ctrl       <= next_capcmp_ctrl;
            timer_output_ctrl <= next_timer_output_ctrl;
            port3_direction   <= next_port3_direction;
            port3_latch       <= next_port3_latch;
            irq_stat          <= next_irq_stat;
            irq_mask          <= next_irq_mask;
            out_ff            <= next_out_ff;
            prediv            <= next_prediv;
            ack               <= next_ack;
            rd_data           <= next_rd_data;
            match_a_irq       <= next_match_a_irq;
            capture_b_irq     <= next_capture_b_irq;
            sync_a            <= {sync_a[0], timer_in_a};
            sync_b            <= {sync_b[0], timer_in_b};
        end
    end

    assign wb_ack_o     = ack;
    assign wb_dat_o     = rd_data;
    assign irq          = |(irq_stat & irq_mask);
    // pin drives only with direction bit 0; latch bit 0 must be low to pass timer output
    assign timer_out_oe = ~port3_direction[0];
    assign timer_out    = (out_ff & timer_output_ctrl[tcc_pkg::tcc_out_en_bit])
                          | port3_latch[0];
endmodule
`default_nettype wire

// File: logic/tcc_pkg.sv
// constants shared by the capture/compare timer files.
// assumes a 32-bit classic wishbone slave, registers one aligned word each.
package tcc_pkg;
    // register byte offsets
    localparam logic [7:0] tcc_off_counter  = 8'h00;
    localparam logic [7:0] tcc_off_reg_a    = 8'h04;
    localparam logic [7:0] tcc_off_reg_b    = 8'h08;
    localparam logic [7:0] tcc_off_prescale = 8'h0c;
    localparam logic [7:0] tcc_off_mode     = 8'h10;
    localparam logic [7:0] tcc_off_capcmp   = 8'h14;
    localparam logic [7:0] tcc_off_outctl   = 8'h18;
    localparam logic [7:0] tcc_off_port3dir = 8'h1c;
    localparam logic [7:0] tcc_off_irq_stat = 8'h20;
    localparam logic [7:0] tcc_off_irq_mask = 8'h24;
    localparam logic [7:0] tcc_off_port3lat = 8'h28;

    // reset values
    localparam logic [7:0] tcc_port3dir_rst = 8'hff;
    localparam logic [7:0] tcc_byte_rst     = 8'h00;

    // prescale mode fields
    localparam int tcc_clk_sel_lo    = 0;
    localparam int tcc_edge_a_sel_lo = 4;
    localparam int tcc_edge_b_sel_lo = 6;

    // count clock sources
    localparam logic [1:0] tcc_clk_main   = 2'h0;
    localparam logic [1:0] tcc_clk_div4   = 2'h1;
    localparam logic [1:0] tcc_clk_div64  = 2'h2;
    localparam logic [1:0] tcc_clk_edge_a = 2'h3;
    localparam logic [5:0] tcc_div4_mask  = 6'h03;
    localparam logic [5:0] tcc_div64_mask = 6'h3f;

    // edge select codes
    localparam logic [1:0] tcc_edge_fall = 2'h0;
    localparam logic [1:0] tcc_edge_rise = 2'h1;
    localparam logic [1:0] tcc_edge_both = 2'h3;

    // operating modes (timer_mode_ctrl bits 1:0)
    localparam logic [1:0] tcc_mode_stop     = 2'h0;
    localparam logic [1:0] tcc_mode_free     = 2'h1;
    localparam logic [1:0] tcc_mode_restart  = 2'h2;
    localparam logic [1:0] tcc_mode_clr_a    = 2'h3;

    // capcmp_ctrl bits
    localparam int tcc_cap_a_bit     = 0;
    localparam int tcc_cap_a_rev_bit = 1;
    localparam int tcc_cap_b_bit     = 2;

    // timer_output_ctrl bits
    localparam int tcc_out_en_bit    = 0;
    localparam int tcc_inv_a_bit     = 1;
    localparam int tcc_lv_clr_bit    = 2;
    localparam int tcc_lv_set_bit    = 3;
    localparam int tcc_inv_b_bit     = 4;

    // interrupt status bits
    localparam int tcc_irq_match_a   = 0;
    localparam int tcc_irq_capture_b = 1;

    localparam logic [15:0] tcc_cnt_zero = 16'h0000;
    localparam logic [15:0] tcc_cnt_one  = 16'h0001;
endpackage

// File: logic/tcc_edge_if.sv
// carrier between the timer top and its input edge detector.
// assumes one clock domain; strobe marks a count-clock sample.
`timescale 1ns/1ps
`default_nettype none
interface tcc_edge_if;
    logic       strobe;
    logic [1:0] sel;
    logic       pin;
    logic       rise;
    logic       fall;
    logic       valid;
    modport det (input strobe, input sel, input pin, output rise, output fall, output valid);
    modport use_side (output strobe, output sel, output pin, input rise, input fall, input valid);
endinterface
`default_nettype wire

// File: logic/tcc_edge_det.sv
// noise-filtered edge detector for one capture input.
// assumes pin is already synchronised to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module tcc_edge_det (
    input  wire logic  sys_clk,
    input  wire logic  nrst,
    tcc_edge_if.det    e
);
    logic s1;
    logic s2;
    logic lvl;
    logic next_s1;
    logic next_s2;
    logic next_lvl;

    // level accepted only after two equal samples on the count clock
    always_comb begin
        next_s1  = s1;
        next_s2  = s2;
        next_lvl = lvl;
        if (e.strobe) begin
            next_s1 = e.pin;
            next_s2 = s1;
            if (s1 == s2) begin
                next_lvl = s2;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s1  <= 1'b0;
            s2  <= 1'b0;
            lvl <= 1'b0;
        end else begin
            s1  <= next_s1;
            s2  <= next_s2;
            lvl <= next_lvl;
        end
    end

    assign e.rise = next_lvl & ~lvl;
    assign e.fall = ~next_lvl & lvl;
    // code 10 is prohibited and detects nothing
    always_comb begin
        case (e.sel)
            tcc_pkg::tcc_edge_fall: e.valid = e.fall;
            tcc_pkg::tcc_edge_rise: e.valid = e.rise;
            tcc_pkg::tcc_edge_both: e.valid = e.rise | e.fall;
            default:                e.valid = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// File: dv/tcc_pulse_src.sv
// external pulse source driving one capture pin of the timer.
// assumes calls start right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module tcc_pulse_src (
    input  wire logic clk,
    output var  logic pin
);
    initial pin = 1'b0;
    // push-pull source, so the idle level is a driven low
    task automatic pulse(input int hi, input int lo);
        pin <= 1'b1;
        repeat (hi) @(posedge clk);
        pin <= 1'b0;
        repeat (lo) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// File: dv/tcc_clk_gen.sv
// free-running 100 MHz system clock for the bench.
// assumes a 1ns time unit.
`timescale 1ns/1ps
`default_nettype none
module tcc_clk_gen (
    output var logic sys_clk
);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
endmodule
`default_nettype wire

// File: dv/tcc_timer_monitor.sv
// concurrent checks on the timer top ports.
// assumes it is bound into tcc_timer.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_monitor #(
    parameter int cnt_width = 16
) (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        timer_in_a,
    input wire logic        timer_in_b,
    input wire logic        timer_out,
    input wire logic        timer_out_oe,
    input wire logic        match_a_irq,
    input wire logic        capture_b_irq,
    input wire logic        irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_dir_wr;
        s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == tcc_pkg::tcc_off_port3dir);
    endsequence
    property p_ack_take;
        s_take |=> wb_ack_o;
    endproperty
    a_ack_take: assert property (p_ack_take) else $error("no ack after request");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_unmapped;
        s_take ##0 (!wb_we_i && wb_adr_i > tcc_pkg::tcc_off_port3lat) |=> wb_dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_match_pulse;
        match_a_irq |=> !match_a_irq;
    endproperty
    a_match_pulse: assert property (p_match_pulse) else $error("match request held");
    property p_cap_pulse;
        capture_b_irq |=> !capture_b_irq;
    endproperty
    a_cap_pulse: assert property (p_cap_pulse) else $error("capture request held");
    property p_dir_oe;
        s_dir_wr |-> ##2 timer_out_oe == !$past(wb_dat_i[0], 2);
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("enable not from direction bit");
    property p_oe_hold;
        $changed(timer_out_oe) |-> $past(wb_adr_i) == tcc_pkg::tcc_off_port3dir
            || $past(wb_adr_i, 2) == tcc_pkg::tcc_off_port3dir;
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("enable moved by itself");
    property p_irq_cause;
        $rose(irq) |-> match_a_irq || capture_b_irq || $past(match_a_irq)
            || $past(capture_b_irq) || $past(match_a_irq, 2) || $past(capture_b_irq, 2)
            || $past(wb_stb_i && wb_we_i);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without event");
endmodule
bind tcc_timer tcc_timer_monitor #(.cnt_width(cnt_width)) u_mon (.*);
`default_nettype wire

// File: dv/timer_capture_compare_modes_tb_top.sv
// self-checking bench for the capture/compare timer.
// assumes pulse sources on both capture pins, one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module timer_capture_compare_modes_tb_top;
    logic        sys_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q, exp_q[$], msk_q[$];
    logic        timer_in_a, timer_in_b, timer_out, timer_out_oe, match_a_irq;
    logic        capture_b_irq, irq;
    logic [15:0] va, vb;
    int          failures = 0, total_checks = 0, cyc_n = 0, cap_n = 0;
    int          t0, t1, t2, n, b;
    int          div[3] = '{1, 4, 64};
    int          ncap[4] = '{1, 1, 0, 2};
    tcc_clk_gen tb_clk (.sys_clk(sys_clk));
    tcc_pulse_src src_a (.clk(sys_clk), .pin(timer_in_a));
    tcc_pulse_src src_b (.clk(sys_clk), .pin(timer_in_b));
    tcc_timer #(.cnt_width(16)) dut (.*);
    always @(posedge sys_clk) cyc_n <= cyc_n + 1;
    always @(posedge sys_clk) if (capture_b_irq === 1'b1) cap_n <= cap_n + 1;
    // read results are compared where they appear, in request order
    always @(posedge sys_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
            chk(wb_dat_o & msk_q.pop_front(), exp_q.pop_front());
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic bad_wait();
        chk(32'h0, 32'h1);
        final_report();
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge sys_clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        if (k >= 50) bad_wait();
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        wb(1'b0, a, 32'h0);
    endtask
    task automatic pk(input logic [7:0] a);
        rd(a, 32'h0, 32'h0);
    endtask
    // timer stopped around every reconfiguration, status emptied
    task automatic cfg(input logic [31:0] md, input logic [31:0] pre, input logic [31:0] cc);
        wr(tcc_pkg::tcc_off_mode, 32'h0);
        wr(tcc_pkg::tcc_off_prescale, pre);
        wr(tcc_pkg::tcc_off_capcmp, cc);
        rd(tcc_pkg::tcc_off_irq_stat, 32'h0, 32'h0);
        wr(tcc_pkg::tcc_off_mode, md);
    endtask
    task automatic wait_sig(input int s, output int t);
        int k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while ((s == 0 ? match_a_irq : s == 2 ? timer_out : !timer_out) !== 1'b1
            && k < 3000);
        if (k >= 3000) bad_wait();
        t = cyc_n;
    endtask
    initial begin
        {nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'hf;
        void'($urandom(11076));
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        rd(tcc_pkg::tcc_off_port3dir, 32'hff, 32'hffffffff);
        chk(timer_out_oe, 1'b0);
        rd(8'h3c, 32'h0, 32'hffffffff);
        wr(tcc_pkg::tcc_off_port3dir, 32'hfe);
        wr(tcc_pkg::tcc_off_port3lat, 32'h0);
        chk(timer_out_oe, 1'b1);
        $display("register test done");
        foreach (div[i]) begin
            n = 1 + $urandom % 6;
            wr(tcc_pkg::tcc_off_reg_a, n);
            cfg(tcc_pkg::tcc_mode_clr_a, i, 0);
            wait_sig(0, t0);
            wait_sig(0, t1);
            chk(t1 - t0, (n + 1) * div[i]);
        end
        cfg(tcc_pkg::tcc_mode_clr_a, 0, 0);
        wr(tcc_pkg::tcc_off_irq_mask, 32'h0);
        wait_sig(0, t0);
        chk(irq, 1'b0);
        wr(tcc_pkg::tcc_off_irq_mask, 32'h1);
        chk(irq, 1'b1);
        wr(tcc_pkg::tcc_off_mode, 32'h0);
        rd(tcc_pkg::tcc_off_irq_stat, 32'h1, 32'h1);
        rd(tcc_pkg::tcc_off_irq_stat, 32'h0, 32'h3);
        chk(irq, 1'b0);
        $display("interval test done");
        for (int c = 0; c < 4; c++) begin
            cfg(tcc_pkg::tcc_mode_free, c << 4, 4);
            cap_n = 0;
            src_a.pulse(6, 10);
            chk(cap_n, ncap[c]);
            rd(tcc_pkg::tcc_off_irq_stat, c == 2 ? 0 : 2, 32'h2);
        end
        for (int w = 1; w < 3; w++) begin
            cfg(tcc_pkg::tcc_mode_free, 32'h10, 4);
            cap_n = 0;
            src_a.pulse(w, 10);
            chk(cap_n, w - 1);
        end
        t0 = cyc_n;
        src_a.pulse(3, 4 + $urandom % 20);
        pk(tcc_pkg::tcc_off_reg_b);
        va = q[15:0];
        t1 = cyc_n;
        src_a.pulse(3, 8);
        pk(tcc_pkg::tcc_off_reg_b);
        chk(16'(q[15:0] - va), t1 - t0);
        cfg(tcc_pkg::tcc_mode_free, 32'h10, 7);
        n = 3 + $urandom % 18;
        src_a.pulse(n, 10);
        pk(tcc_pkg::tcc_off_reg_a);
        va = q[15:0];
        pk(tcc_pkg::tcc_off_reg_b);
        chk(16'(va - q[15:0]), n);
        cfg(tcc_pkg::tcc_mode_free, 32'h50, 5);
        t0 = cyc_n;
        src_a.pulse(4, 0);
        t1 = cyc_n;
        src_b.pulse(4, 10);
        pk(tcc_pkg::tcc_off_reg_a);
        va = q[15:0];
        pk(tcc_pkg::tcc_off_reg_b);
        chk(16'(va - q[15:0]), t1 - t0);
        rd(tcc_pkg::tcc_off_irq_stat, 32'h3, 32'h3);
        cfg(tcc_pkg::tcc_mode_restart, 32'h10, 4);
        n = 8 + $urandom % 20;
        src_a.pulse(3, n - 3);
        src_a.pulse(3, 8);
        rd(tcc_pkg::tcc_off_reg_b, n - 1, 32'hffff);
        cfg(tcc_pkg::tcc_mode_free, 32'h13, 0);
        pk(tcc_pkg::tcc_off_counter);
        va = q[15:0];
        n = 2 + $urandom % 5;
        repeat (n) src_a.pulse(5, 5);
        pk(tcc_pkg::tcc_off_counter);
        chk(16'(q[15:0] - va), n);
        $display("capture test done");
        n = 8 + $urandom % 8;
        b = 1 + $urandom % (n - 1);
        wr(tcc_pkg::tcc_off_reg_a, n);
        wr(tcc_pkg::tcc_off_reg_b, b);
        wr(tcc_pkg::tcc_off_outctl, 32'h13);
        cfg(tcc_pkg::tcc_mode_clr_a, 0, 0);
        wait_sig(2, t0);
        wait_sig(3, t0);
        wait_sig(2, t0);
        wait_sig(3, t1);
        wait_sig(2, t2);
        chk(t1 - t0, b + 1);
        chk(t2 - t0, n + 1);
        $display("pulse test done");
        final_report();
    end
endmodule
`default_nettype wire
